//--- rtl/timer8_regs.svh
// register offsets, field positions, reset values and timing counts
// of one 8-bit timer channel; definitions only, included by bare name
`ifndef TIMER8_REGS_SVH
`define TIMER8_REGS_SVH

// register port address width and word offsets
`define TMR_ADDR_W        3
`define TMR_OFS_COUNT     3'h0
`define TMR_OFS_CMP_A     3'h1
`define TMR_OFS_CMP_B     3'h2
`define TMR_OFS_CTRL      3'h3
`define TMR_OFS_CLKCTL    3'h4
`define TMR_OFS_STATUS    3'h5

// match_status_control fields
`define TMR_BIT_WRAP      5
`define TMR_BIT_FLAG_A    6
`define TMR_BIT_FLAG_B    7
`define TMR_BIT_ADC_TRIGGER_ENABLE      4
`define TMR_OS_MSB        3
`define TMR_OS_LSB        0

// timer_control and timer_clock_control fields
`define TMR_CLR_MSB       4
`define TMR_CLR_LSB       3
`define TMR_BIT_LVL_SEL   3

// reset values, odd-channel reserved bit value and counter maximum
`define TMR_RST_COUNT     8'h00
`define TMR_RST_CMP       8'hff
`define TMR_RST_CLR       2'h0
`define TMR_RST_OS        4'h0
`define TMR_RST_FLAGS     3'h0
`define TMR_RSVD_ODD      1'h1
`define TMR_COUNT_MAX     8'hff

// least width of an external clear pulse, in clock cycles
`define TMR_EXT_CLR_MIN_CYC 2

`endif

//--- rtl/timer8_pkg.sv
// types shared by the timer channel and its output stage
// assumes the offsets and fields of timer8_regs.svh
package timer8_pkg;

    // counter clear source, clear_sel_hi/clear_sel_lo
    typedef enum logic [1:0] {
        CLR_NONE  = 2'h0,
        CLR_ON_A  = 2'h1,
        CLR_ON_B  = 2'h2,
        CLR_ON_EXT = 2'h3
    } clear_sel_t;

    // action of the output pin on one compare match
    typedef enum logic [1:0] {
        OUT_KEEP   = 2'h0,
        OUT_DRIVE0 = 2'h1,
        OUT_DRIVE1 = 2'h2,
        OUT_TOGGLE = 2'h3
    } out_act_t;

endpackage : timer8_pkg

//--- rtl/timer8_pin_ctrl.sv
// timer output pin stage: applies the compare-match actions to the pin
// assumes match pulses are one clock wide and come from the channel
`timescale 1ns/1ps

module timer8_pin_ctrl (
    input  wire logic       clk,       // peripheral clock
    input  wire logic       rst_n,     // async reset, active low
    input  wire logic       match_a,   // compare match a pulse
    input  wire logic       match_b,   // compare match b pulse
    input  wire logic [3:0] out_sel,   // output select, b in 3:2, a in 1:0
    output logic            pin_out,   // timer output level
    output logic            pin_en     // timer output enable
);

    timer8_pkg::out_act_t act_a;       // action chosen for match a
    timer8_pkg::out_act_t act_b;       // action chosen for match b
    logic                 pin_reg;     // registered pin level
    logic                 pin_next;    // next pin level

    assign act_a = timer8_pkg::out_act_t'(out_sel[1:0]);
    assign act_b = timer8_pkg::out_act_t'(out_sel[3:2]);

    ////////////////////////////////////////////////////////////////////////
    // next pin level; both matches at once resolve by priority
    always_comb begin
        pin_next = pin_reg;
        if ((match_a && act_a == timer8_pkg::OUT_TOGGLE) ||
            (match_b && act_b == timer8_pkg::OUT_TOGGLE)) begin
            pin_next = ~pin_reg;
        end else if ((match_a && act_a == timer8_pkg::OUT_DRIVE1) ||
                     (match_b && act_b == timer8_pkg::OUT_DRIVE1)) begin
            pin_next = 1'b1;
        end else if ((match_a && act_a == timer8_pkg::OUT_DRIVE0) ||
                     (match_b && act_b == timer8_pkg::OUT_DRIVE0)) begin
            pin_next = 1'b0;
        end
    end

    // level register; stays 0 from reset until a match moves it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_reg <= 1'b0;
        end else begin
            pin_reg <= pin_next;
        end
    end

    assign pin_out = pin_reg;
    assign pin_en  = (out_sel != 4'h0);

    ////////////////////////////////////////////////////////////////////////
    // checks on the pin stage
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_pin_b_low: assert property (match_b && !match_a &&
        act_b == timer8_pkg::OUT_DRIVE0 |=> !pin_out)
        else $error("match b drive-0 did not lower the pin");

    a_pin_a_high: assert property (match_a && !match_b &&
        act_a == timer8_pkg::OUT_DRIVE1 |=> pin_out)
        else $error("match a drive-1 did not raise the pin");

    a_pin_disabled: assert property (out_sel == 4'h0 |-> !pin_en)
        else $error("pin enabled with all output selects zero");

    a_pin_toggle_wins: assert property (match_a && match_b &&
        (act_a == timer8_pkg::OUT_TOGGLE ||
         act_b == timer8_pkg::OUT_TOGGLE) |=> pin_out != $past(pin_out))
        else $error("toggle did not win over the other match");

    a_pin_quiet: assert property (!match_a && !match_b |=>
        $stable(pin_out))
        else $error("pin moved without a compare match");

endmodule : timer8_pin_ctrl

//--- rtl/timer8_match_status_output.sv
// 8-bit timer channel: counter, compare a/b, status flags, output pin
// and a/d start request; assumes count_tick is a one-cycle enable from
// the clock-select logic and the register port follows the local bus
//
// Summary of operation
// - counter equals compare b sets match_b_flag
// - counter equals compare a sets match_a_flag
// - flags clear by read one, write zero
// - transfer service clears match flag when enabled
// - wrap ff to 00 sets wrap_flag
// - even channel: match a requests a/d start
// - match b drives pin per out_sel_b
// - match a drives pin per out_sel_a
// - selects all zero disable pin; reset low
// - odd channel bit 4 reads one, ignores writes
// - clear select 01 clears counter on match a
// - clear select 11, level mode: high clears
// - counter clears on match a or b
// - external clear by edge or level, two cycles
// - match fires in last state before count
// - simultaneous matches resolve toggle, one, zero
// - a/d request when match a sets flag
`timescale 1ns/1ps
`include "timer8_regs.svh"

module timer8_match_status_output #(
    parameter bit EVEN_CHANNEL = 1'b1,   // channel holds the a/d enable bit
    parameter bit HAS_XFER_EXT = 1'b1    // transfer clear and ext reset exist
) (
    input  wire logic                   clk,        // peripheral clock
    input  wire logic                   rst_n,      // async reset, low
    input  wire logic [`TMR_ADDR_W-1:0] addr,       // register address
    input  wire logic [7:0]             wdata,      // register write data
    input  wire logic                   wr_en,      // write strobe
    input  wire logic                   rd_en,      // read strobe
    output logic      [7:0]             rdata,      // read data, next cycle
    input  wire logic                   count_tick, // count enable pulse
    input  wire logic                   ext_reset_input, // external clear
    input  wire logic                   xfer_ack_a, // transfer served a
    input  wire logic                   xfer_ack_b, // transfer served b
    input  wire logic                   irq_disable_select_a, // a: no clr
    input  wire logic                   irq_disable_select_b, // b: no clr
    output logic                        match_a_irq, // match a flag level
    output logic                        match_b_irq, // match b flag level
    output logic                        adc_start_req, // a/d start pulse
    output logic                        timer_output_pin, // timer output
    output logic                        timer_output_en   // output enable
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    logic [7:0]              count_reg, count_next;  // count_value
    logic [7:0]              cmp_a_reg, cmp_a_next;  // compare_a_value
    logic [7:0]              cmp_b_reg, cmp_b_next;  // compare_b_value
    timer8_pkg::clear_sel_t  clr_sel_reg, clr_sel_next; // clear source
    logic                    lvl_sel_reg, lvl_sel_next; // ext level mode
    logic                    adc_trigger_enable_reg, adc_trigger_enable_next;    // a/d trigger enable
    logic [3:0]              os_reg, os_next;        // output selects
    logic                    ext_prev_reg, ext_prev_next; // edge history
    logic [7:0]              rdata_reg, rdata_next;  // read data holder

    // flags: index 0 wrap, 1 match a, 2 match b (bits 5..7)
    logic [2:0]              flag_reg, flag_next;    // sticky flags
    logic [2:0]              armed_reg, armed_next;  // read-as-one seen
    logic [2:0]              flag_set;               // hardware set
    logic [2:0]              flag_hw_clr;            // transfer clear
    logic [2:0]              flag_sw_clr;            // software clear

    logic                    wr_count, wr_cmp_a, wr_cmp_b; // write decode
    logic                    wr_ctrl, wr_clkctl, wr_status;
    logic                    rd_status;              // status read
    logic                    match_a, match_b;       // match pulses
    logic                    wrap;                   // ff to 00 step
    logic                    ext_clr;                // external clear
    logic                    ctr_clear;              // any counter clear
    logic [7:0]              status_view;            // status as read

    ////////////////////////////////////////////////////////////////////////
    // address decode; unmapped offsets write nothing and read zero

    assign wr_count  = wr_en && (addr == `TMR_OFS_COUNT);
    assign wr_cmp_a  = wr_en && (addr == `TMR_OFS_CMP_A);
    assign wr_cmp_b  = wr_en && (addr == `TMR_OFS_CMP_B);
    assign wr_ctrl   = wr_en && (addr == `TMR_OFS_CTRL);
    assign wr_clkctl = wr_en && (addr == `TMR_OFS_CLKCTL);
    assign wr_status = wr_en && (addr == `TMR_OFS_STATUS);
    assign rd_status = rd_en && (addr == `TMR_OFS_STATUS);

    ////////////////////////////////////////////////////////////////////////
    // compare match and wrap events
    // a match fires only on the tick that would move the counter off the
    // matching value, so a flag sets in the last state of the match;
    // a compare write in that cycle wins and suppresses the match

    assign match_a = count_tick && (count_reg == cmp_a_reg)
                     && !wr_cmp_a;
    assign match_b = count_tick && (count_reg == cmp_b_reg)
                     && !wr_cmp_b;
    assign wrap    = count_tick && (count_reg == `TMR_COUNT_MAX)
                     && !wr_count;

    // external clear; edge mode looks at the registered previous level
    always_comb begin
        ext_clr = 1'b0;
        if (HAS_XFER_EXT && clr_sel_reg == timer8_pkg::CLR_ON_EXT) begin
            if (lvl_sel_reg) begin
                ext_clr = ext_reset_input;
            end else begin
                ext_clr = ext_reset_input && !ext_prev_reg;
            end
        end
    end

    // counter clear sources
    assign ctr_clear =
        (clr_sel_reg == timer8_pkg::CLR_ON_A && match_a) ||
        (clr_sel_reg == timer8_pkg::CLR_ON_B && match_b) ||
        ext_clr;

    ////////////////////////////////////////////////////////////////////////
    // counter: clear beats a write, a write beats an increment

    always_comb begin
        count_next    = count_reg;
        ext_prev_next = ext_reset_input;
        if (ctr_clear) begin
            count_next = `TMR_RST_COUNT;
        end else if (wr_count) begin
            count_next = wdata;
        end else if (count_tick) begin
            count_next = count_reg + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg    <= `TMR_RST_COUNT;
            ext_prev_reg <= 1'b0;
        end else begin
            count_reg    <= count_next;
            ext_prev_reg <= ext_prev_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration registers written by software

    always_comb begin
        cmp_a_next   = cmp_a_reg;
        cmp_b_next   = cmp_b_reg;
        clr_sel_next = clr_sel_reg;
        lvl_sel_next = lvl_sel_reg;
        adc_trigger_enable_next    = adc_trigger_enable_reg;
        os_next      = os_reg;
        if (wr_cmp_a) begin
            cmp_a_next = wdata;
        end
        if (wr_cmp_b) begin
            cmp_b_next = wdata;
        end
        if (wr_ctrl) begin
            clr_sel_next = timer8_pkg::clear_sel_t'(
                wdata[`TMR_CLR_MSB:`TMR_CLR_LSB]);
        end
        if (wr_clkctl) begin
            lvl_sel_next = wdata[`TMR_BIT_LVL_SEL];
        end
        if (wr_status) begin
            os_next = wdata[`TMR_OS_MSB:`TMR_OS_LSB];
            // odd channel has no enable bit; its bit 4 ignores writes
            if (EVEN_CHANNEL) begin
                adc_trigger_enable_next = wdata[`TMR_BIT_ADC_TRIGGER_ENABLE];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_a_reg   <= `TMR_RST_CMP;
            cmp_b_reg   <= `TMR_RST_CMP;
            clr_sel_reg <= timer8_pkg::CLR_NONE;
            lvl_sel_reg <= 1'b0;
            adc_trigger_enable_reg    <= 1'b0;
            os_reg      <= `TMR_RST_OS;
        end else begin
            cmp_a_reg   <= cmp_a_next;
            cmp_b_reg   <= cmp_b_next;
            clr_sel_reg <= clr_sel_next;
            lvl_sel_reg <= lvl_sel_next;
            adc_trigger_enable_reg    <= adc_trigger_enable_next;
            os_reg      <= os_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status flags; a flag is armed when a status read returns it as one,
    // and only an armed flag clears on a written zero, so a flag that set
    // after the read survives a blind clearing write

    assign flag_set    = {match_b, match_a, wrap};
    assign flag_hw_clr = HAS_XFER_EXT ?
        {xfer_ack_b && !irq_disable_select_b,
         xfer_ack_a && !irq_disable_select_a, 1'b0} : 3'h0;

    for (genvar i = 0; i < 3; i++) begin : g_flag
        // written zero after a read as one; a written one does nothing
        assign flag_sw_clr[i] = wr_status && armed_reg[i]
                                && !wdata[`TMR_BIT_WRAP + i];
        // a hardware set in the same cycle wins over any clear
        assign flag_next[i]  = flag_set[i] ||
            (flag_reg[i] && !flag_sw_clr[i] && !flag_hw_clr[i]);
        assign armed_next[i] = (rd_status && flag_reg[i]) ||
            (armed_reg[i] && !wr_status && flag_reg[i]);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_reg  <= `TMR_RST_FLAGS;
            armed_reg <= `TMR_RST_FLAGS;
        end else begin
            flag_reg  <= flag_next;
            armed_reg <= armed_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path; data stand for exactly the cycle after the strobe

    assign status_view = {flag_reg,
        (EVEN_CHANNEL ? adc_trigger_enable_reg : `TMR_RSVD_ODD),
        os_reg};

    always_comb begin
        rdata_next = 8'h00;
        if (rd_en) begin
            unique case (addr)
                `TMR_OFS_COUNT:  rdata_next = count_reg;
                `TMR_OFS_CMP_A:  rdata_next = cmp_a_reg;
                `TMR_OFS_CMP_B:  rdata_next = cmp_b_reg;
                `TMR_OFS_CTRL: begin
                    rdata_next[`TMR_CLR_MSB:`TMR_CLR_LSB] = clr_sel_reg;
                end
                `TMR_OFS_CLKCTL: rdata_next[`TMR_BIT_LVL_SEL] = lvl_sel_reg;
                `TMR_OFS_STATUS: rdata_next = status_view;
                default:         rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // outward requests; the a/d request pulses with the match that sets
    // the a flag, and only the even channel can raise it

    assign adc_start_req = EVEN_CHANNEL && adc_trigger_enable_reg && match_a;
    assign match_a_irq   = flag_reg[1];
    assign match_b_irq   = flag_reg[2];

    // output pin stage
    timer8_pin_ctrl u_pin (
        .clk     (clk),
        .rst_n   (rst_n),
        .match_a (match_a),
        .match_b (match_b),
        .out_sel (os_reg),
        .pin_out (timer_output_pin),
        .pin_en  (timer_output_en)
    );

    ////////////////////////////////////////////////////////////////////////
    // checks on the channel

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_status_read;
        rd_status;
    endsequence

    sequence s_read_then_zero;
        rd_status && flag_reg[1] ##1 (wr_status && !wdata[`TMR_BIT_FLAG_A]
                                      && !match_a);
    endsequence

    a_flag_b_set: assert property (match_b |=> match_b_irq)
        else $error("match b did not set its flag");

    a_flag_a_set: assert property (match_a |=> match_a_irq)
        else $error("match a did not set its flag");

    a_flag_read_clear: assert property (s_read_then_zero |=>
        !match_a_irq)
        else $error("read then zero write did not clear flag a");

    a_flag_one_keeps: assert property (flag_reg[1] && wr_status &&
        wdata[`TMR_BIT_FLAG_A] |=> flag_reg[1])
        else $error("writing one cleared flag a");

    a_xfer_clears: assert property (HAS_XFER_EXT && flag_reg[2] &&
        xfer_ack_b && !irq_disable_select_b && !match_b |=> !flag_reg[2])
        else $error("transfer service did not clear flag b");

    a_wrap_sets: assert property (wrap |=> flag_reg[0] &&
        count_reg == `TMR_RST_COUNT)
        else $error("wrap did not set flag or reach zero");

    a_adc_request: assert property (match_a && adc_trigger_enable_reg &&
        EVEN_CHANNEL |-> adc_start_req ##1 match_a_irq)
        else $error("a/d request missing on match a");

    a_odd_reserved: assert property ((!EVEN_CHANNEL and s_status_read)
        |=> rdata[`TMR_BIT_ADC_TRIGGER_ENABLE])
        else $error("odd channel bit 4 read as zero");

    a_clear_on_a: assert property (match_a &&
        clr_sel_reg == timer8_pkg::CLR_ON_A |=> count_reg == 8'h00)
        else $error("counter not cleared on match a");

    a_ext_level: assert property (HAS_XFER_EXT && ext_reset_input &&
        lvl_sel_reg && clr_sel_reg == timer8_pkg::CLR_ON_EXT
        |=> count_reg == 8'h00)
        else $error("external level did not clear the counter");

    a_match_timing: assert property (match_b |-> count_tick &&
        count_reg == cmp_b_reg)
        else $error("match b fired outside its last state");

    a_set_wins: assert property (match_a && wr_status &&
        !wdata[`TMR_BIT_FLAG_A] |=> match_a_irq)
        else $error("clearing write lost a match a event");

endmodule : timer8_match_status_output

//--- bench/xfer_ctrl_model.sv
// stand-in for the transfer controller that serves match requests
// assumes request levels come straight from the timer's flag outputs
`timescale 1ns/1ps

module xfer_ctrl_model (
    input  wire logic clk,    // peripheral clock
    input  wire logic rst_n,  // async reset, active low
    input  wire logic serve,  // bench lets service run
    input  wire logic req_a,  // match a request level
    input  wire logic req_b,  // match b request level
    output logic      ack_a,  // one-cycle service pulse a
    output logic      ack_b   // one-cycle service pulse b
);
    logic done_a;  // request a served, wait for its level to drop
    logic done_b;  // request b served, wait for its level to drop
    //////////////////////////////////////////////////////////////////////
    // one pulse per raised request; a request that stays up is not served
    // twice while serve stays high, so a kept flag cannot be mistaken for a new one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_a  <= 1'b0;
            ack_b  <= 1'b0;
            done_a <= 1'b0;
            done_b <= 1'b0;
        end else begin
            ack_a  <= serve && req_a && !done_a && !ack_a;
            ack_b  <= serve && req_b && !done_b && !ack_b;
            done_a <= serve && req_a && (done_a || ack_a);
            done_b <= serve && req_b && (done_b || ack_b);
        end
    end
endmodule : xfer_ctrl_model

//--- bench/test_timer8_match_status_output.sv
// self-checking bench of one timer channel, even and odd instance
// assumes the register offsets and fields of timer8_regs.svh
`timescale 1ns/1ps
`include "timer8_regs.svh"

module test_timer8_match_status_output;
    logic       clk, rst_n, wr_en, rd_en, count_tick, ext_reset_input;
    logic       serve, dis_a, dis_b, ack_a, ack_b, irq_a, irq_b;
    logic       adc, pin, pin_en;
    logic [2:0] addr;                    // register address
    logic [7:0] wdata, rdata, rdata_odd; // bus data, both channels
    logic [7:0] d, od;                   // last read, even and odd
    int miscompares = 0;
    int n_checks = 0;
    int cycles = 0;
    //////////////////////////////////////////////////////////////////////
    timer8_match_status_output timer8_match_status_output_i (
        .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .count_tick(count_tick), .ext_reset_input(ext_reset_input),
        .xfer_ack_a(ack_a), .xfer_ack_b(ack_b),
        .irq_disable_select_a(dis_a), .irq_disable_select_b(dis_b),
        .match_a_irq(irq_a), .match_b_irq(irq_b), .adc_start_req(adc),
        .timer_output_pin(pin), .timer_output_en(pin_en));
    // odd channel shares every input, only its read data is watched
    timer8_match_status_output #(.EVEN_CHANNEL(1'b0))
        timer8_match_status_output_odd_i (
        .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata_odd),
        .count_tick(count_tick), .ext_reset_input(ext_reset_input),
        .xfer_ack_a(ack_a), .xfer_ack_b(ack_b),
        .irq_disable_select_a(dis_a), .irq_disable_select_b(dis_b),
        .match_a_irq(), .match_b_irq(), .adc_start_req(),
        .timer_output_pin(), .timer_output_en());
    xfer_ctrl_model xfer_ctrl_model_i (.clk(clk), .rst_n(rst_n),
        .serve(serve), .req_a(irq_a), .req_b(irq_b),
        .ack_a(ack_a), .ack_b(ack_b));
    //////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // hang guard, far above the about 120 cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            report_and_stop();
        end
    end
    //////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        #1;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        d  = rdata;
        od = rdata_odd;
    endtask : rd
    // status read, then a write in the very next cycle
    task automatic rd_wr(input logic [7:0] v);
        @(posedge clk);
        addr  <= `TMR_OFS_STATUS;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        wr_en <= 1'b1;
        wdata <= v;
        #1;
        d = rdata;
        @(posedge clk);
        wr_en <= 1'b0;
        #1;
        chk(rdata, 8'h00);
    endtask : rd_wr
    // one count pulse; the a/d request is looked at in its own cycle
    task automatic tick(input logic e_adc);
        @(posedge clk);
        count_tick <= 1'b1;
        #1;
        chk(adc, e_adc);
        @(posedge clk);
        count_tick <= 1'b0;
        #1;
    endtask : tick
    // count pulse with a status write in the same cycle
    task automatic tick_wr(input logic [7:0] v);
        @(posedge clk);
        count_tick <= 1'b1;
        addr       <= `TMR_OFS_STATUS;
        wdata      <= v;
        wr_en      <= 1'b1;
        @(posedge clk);
        count_tick <= 1'b0;
        wr_en      <= 1'b0;
        #1;
    endtask : tick_wr
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop
    //////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd(`TMR_OFS_STATUS);
        chk(d, 8'h00);
        chk(od, 8'h10);
        chk(pin_en, 1'b0);
        wr(`TMR_OFS_STATUS, 8'h03);
        rd(`TMR_OFS_STATUS);
        chk(od, 8'h13);
        chk(pin_en, 1'b1);
        chk(pin, 1'b0);
    endtask : t_reset
    // period on a with set-on-a, then flag clearing by read and zero
    task automatic t_match_a();
        wr(`TMR_OFS_CMP_A, 8'h03);
        wr(`TMR_OFS_COUNT, 8'h03);
        wr(`TMR_OFS_CTRL, 8'h08);
        wr(`TMR_OFS_STATUS, 8'h16);
        chk(irq_a, 1'b0);
        tick(1'b1);
        chk(irq_a, 1'b1);
        chk(pin, 1'b1);
        rd(`TMR_OFS_COUNT);
        chk(d, 8'h00);
        wr(`TMR_OFS_STATUS, 8'h16);
        rd(`TMR_OFS_STATUS);
        chk(d, 8'h56);
        wr(`TMR_OFS_STATUS, 8'hf6);
        rd_wr(8'h16);
        chk(d, 8'h56);
        rd(`TMR_OFS_STATUS);
        chk(d, 8'h16);
    endtask : t_match_a
    task automatic t_match_b();
        wr(`TMR_OFS_CTRL, 8'h00);
        wr(`TMR_OFS_CMP_B, 8'h01);
        wr(`TMR_OFS_COUNT, 8'h01);
        tick(1'b0);
        chk(irq_b, 1'b1);
        chk(pin, 1'b0);
    endtask : t_match_b
    // toggle on b against drive-0 on a, both at once, clear on b
    task automatic t_prio();
        wr(`TMR_OFS_CMP_A, 8'h05);
        wr(`TMR_OFS_CMP_B, 8'h05);
        wr(`TMR_OFS_STATUS, 8'h0d);
        wr(`TMR_OFS_CTRL, 8'h10);
        wr(`TMR_OFS_COUNT, 8'h05);
        tick(1'b0);
        chk(pin, 1'b1);
        rd(`TMR_OFS_COUNT);
        chk(d, 8'h00);
        rd(`TMR_OFS_STATUS);
        chk(d, 8'hcd);
        wr(`TMR_OFS_COUNT, 8'h05);
        tick_wr(8'h0d);
        chk(irq_a, 1'b1);
        chk(pin, 1'b0);
        wr(`TMR_OFS_COUNT, 8'hff);
        tick(1'b0);
        rd(`TMR_OFS_STATUS);
        chk(d & 8'h20, 8'h20);
    endtask : t_prio
    task automatic t_xfer();
        @(posedge clk);
        serve <= 1'b1;
        dis_a <= 1'b1;
        dis_b <= 1'b1;
        repeat (4) @(posedge clk);
        serve <= 1'b0;
        dis_a <= 1'b0;
        #1;
        chk(irq_a, 1'b1);
        @(posedge clk);
        serve <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk(irq_a, 1'b0);
        chk(irq_b, 1'b1);
        @(posedge clk);
        serve <= 1'b0;
        dis_b <= 1'b0;
        @(posedge clk);
        serve <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk(irq_b, 1'b0);
    endtask : t_xfer
    task automatic t_ext();
        wr(`TMR_OFS_CLKCTL, 8'h08);
        wr(`TMR_OFS_CTRL, 8'h18);
        wr(`TMR_OFS_COUNT, 8'h40);
        @(posedge clk);
        ext_reset_input <= 1'b1;
        repeat (2) @(posedge clk);
        ext_reset_input <= 1'b0;
        rd(`TMR_OFS_COUNT);
        chk(d, 8'h00);
        wr(`TMR_OFS_CLKCTL, 8'h00);
        wr(`TMR_OFS_COUNT, 8'h40);
        @(posedge clk);
        ext_reset_input <= 1'b1;
        repeat (2) @(posedge clk);
        tick(1'b0);
        ext_reset_input <= 1'b0;
        rd(`TMR_OFS_COUNT);
        chk(d, 8'h01);
    endtask : t_ext
    //////////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, wr_en, rd_en, count_tick, ext_reset_input} = 5'h00;
        {serve, dis_a, dis_b, addr, wdata} = 14'h0000;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_match_a();
        t_match_b();
        t_prio();
        t_xfer();
        t_ext();
        report_and_stop();
    end
endmodule : test_timer8_match_status_output
